// >>> core/vld_pkg.sv
// package: types and constants shared by the instruction decoder files
package vld_pkg;

  localparam logic [7:0] OPC_ESCAPE = 8'hfd;
  localparam logic [2:0] MAX_OPS = 3'h6;
  localparam logic [3:0] REG_PC = 4'hf;
  localparam logic [3:0] MODE_LIT_TOP = 4'h3;
  localparam logic [3:0] MODE_INDEX = 4'h4;
  localparam logic [3:0] MODE_REG = 4'h5;
  localparam logic [3:0] MODE_AUTODEC = 4'h7;
  localparam logic [3:0] MODE_AUTOINC = 4'h8;
  localparam logic [3:0] MODE_AUTOINC_DEF = 4'h9;
  localparam logic [3:0] EXT_LONG = 4'h4;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_FAULT_PC = 12'h008;
  localparam logic [11:0] OFS_INT_STAT = 12'h00c;
  localparam logic [11:0] OFS_INT_CLR = 12'h010;
  localparam logic [11:0] OFS_INT_EN = 12'h014;
  localparam logic RST_CTRL_EN = 1'b0;
  localparam logic [2:0] RST_INT_EN = 3'h0;
  localparam int INT_FAULT = 0;
  localparam int INT_UNPRED = 1;
  localparam int INT_ISSUE = 2;

  typedef enum logic [2:0] {
    ACC_NONE = 3'h0, ACC_R = 3'h1, ACC_M = 3'h2, ACC_W = 3'h3,
    ACC_A = 3'h4, ACC_V = 3'h5
  } vld_acc_e;
  typedef enum logic [1:0] {
    CC_KEEP = 2'h0, CC_RES = 2'h1, CC_CLR = 2'h2, CC_ONE = 2'h3
  } vld_cc_e;
  typedef enum logic [1:0] {
    SZ_B = 2'h0, SZ_W = 2'h1, SZ_L = 2'h2, SZ_Q = 2'h3
  } vld_sz_e;
  typedef enum logic [6:0] {
    S_OPC1 = 7'h01, S_OPC2 = 7'h02, S_LOOK = 7'h04, S_SPEC = 7'h08,
    S_EXT = 7'h10, S_DISP = 7'h20, S_DONE = 7'h40
  } vld_state_e;

  typedef struct packed {vld_acc_e acc; vld_sz_e sz;} vld_opd_s;
  typedef struct packed {
    logic known; logic [2:0] nops; vld_opd_s [5:0] opd; logic [1:0] disp_len;
    vld_cc_e cc_n; vld_cc_e cc_z; vld_cc_e cc_v; vld_cc_e cc_c;
    logic trap_iov; logic trap_idvz;
  } vld_info_s;
  typedef struct packed {logic valid; logic [7:0] data; logic [31:0] pc;} vld_qbyte_s;
  typedef struct packed {
    logic valid; logic [2:0] num; logic indexed; logic [3:0] idx_reg;
    logic [3:0] mode; logic [3:0] gen_reg; logic pcrel; vld_opd_s opd;
    logic [31:0] ext; logic unpred;
  } vld_spec_s;
  typedef struct packed {
    logic valid; logic [8:0] opcode; logic [31:0] pc; vld_info_s info;
    logic [31:0] disp; logic unpred;
  } vld_insn_s;
  typedef struct packed {logic valid; logic [31:0] pc; logic [8:0] opcode;} vld_fault_s;

endpackage : vld_pkg

// >>> core/vld_opc_table.sv
// opcode table: operand layout, displacement and flag effects per opcode
`timescale 1ns/10ps
`default_nettype none
module vld_opc_table (
  input wire logic [8:0] opcode,
  output vld_pkg::vld_info_s info
);
  import vld_pkg::*;

  function automatic vld_opd_s od(vld_acc_e a, vld_sz_e s);
    od.acc = a;
    od.sz = s;
  endfunction : od

  function automatic vld_sz_e sz_of(logic [7:0] op);
    unique case (op[7:4])
      4'h8, 4'h9: sz_of = SZ_B;
      4'ha, 4'hb: sz_of = SZ_W;
      default: sz_of = SZ_L;
    endcase
  endfunction : sz_of

  vld_sz_e s;
  vld_opd_s n;

  always_comb begin
    s = sz_of(opcode[7:0]);
    n = od(ACC_NONE, SZ_B);
    info = '0;
    info.known = ~opcode[8];
    if (!opcode[8]) begin
      unique case (opcode[7:0])
        8'h58, 8'h80, 8'hc0, 8'ha0, 8'hd8: begin
          info = '{1'b1, 3'h2, {n, n, n, n, od(ACC_M, s), od(ACC_R, s)},
                   2'h0, CC_RES, CC_RES, CC_RES, CC_RES, 1'b1, 1'b0};
          if (opcode[7:0] == 8'h58) info.opd[1:0] = {od(ACC_M, SZ_W), od(ACC_R, SZ_W)};
        end
        8'h81, 8'hc1, 8'ha1: info = '{1'b1, 3'h3, {n, n, n, od(ACC_W, s),
          od(ACC_R, s), od(ACC_R, s)}, 2'h0, CC_RES, CC_RES, CC_RES, CC_RES,
          1'b1, 1'b0};
        8'h78, 8'h79: info = '{1'b1, 3'h3, {n, n, n,
          od(ACC_W, opcode[0] ? SZ_Q : SZ_L), od(ACC_R, opcode[0] ? SZ_Q : SZ_L),
          od(ACC_R, SZ_B)}, 2'h0, CC_RES, CC_RES, CC_RES, CC_CLR, 1'b1, 1'b0};
        8'h8a, 8'hca, 8'haa, 8'h88, 8'hc8, 8'ha8: info = '{1'b1, 3'h2,
          {n, n, n, n, od(ACC_M, s), od(ACC_R, s)}, 2'h0, CC_RES, CC_RES,
          CC_CLR, CC_KEEP, 1'b0, 1'b0};
        8'h8b, 8'hcb, 8'hab, 8'h89, 8'hc9, 8'ha9: info = '{1'b1, 3'h3,
          {n, n, n, od(ACC_W, s), od(ACC_R, s), od(ACC_R, s)}, 2'h0, CC_RES,
          CC_RES, CC_CLR, CC_KEEP, 1'b0, 1'b0};
        8'h93, 8'hd3, 8'hb3: info = '{1'b1, 3'h2, {n, n, n, n, od(ACC_R, s),
          od(ACC_R, s)}, 2'h0, CC_RES, CC_RES, CC_CLR, CC_KEEP, 1'b0, 1'b0};
        8'h94, 8'hd4, 8'hb4, 8'h7c: info = '{1'b1, 3'h1, {n, n, n, n, n,
          od(ACC_W, opcode[7:0] == 8'h7c ? SZ_Q : s)}, 2'h0, CC_CLR, CC_ONE,
          CC_CLR, CC_KEEP, 1'b0, 1'b0};
        8'h91, 8'hd1, 8'hb1: info = '{1'b1, 3'h2, {n, n, n, n, od(ACC_R, s),
          od(ACC_R, s)}, 2'h0, CC_RES, CC_RES, CC_CLR, CC_RES, 1'b0, 1'b0};
        8'h98, 8'h99, 8'h32: info = '{1'b1, 3'h2, {n, n, n, n,
          od(ACC_W, opcode[7:0] == 8'h99 ? SZ_W : SZ_L),
          od(ACC_R, opcode[7:0] == 8'h32 ? SZ_W : SZ_B)}, 2'h0, CC_RES,
          CC_RES, CC_CLR, CC_CLR, 1'b0, 1'b0};
        8'hf6, 8'hf7, 8'h33: info = '{1'b1, 3'h2, {n, n, n, n,
          od(ACC_W, opcode[7:0] == 8'hf7 ? SZ_W : SZ_B),
          od(ACC_R, opcode[7:0] == 8'h33 ? SZ_W : SZ_L)}, 2'h0, CC_RES,
          CC_RES, CC_RES, CC_CLR, 1'b1, 1'b0};
        8'h97, 8'hd7, 8'hb7, 8'h96, 8'hd6, 8'hb6: info = '{1'b1, 3'h1,
          {n, n, n, n, n, od(ACC_M, s)}, 2'h0, CC_RES, CC_RES, CC_RES, CC_RES,
          1'b1, 1'b0};
        8'h86, 8'hc6, 8'ha6: info = '{1'b1, 3'h2, {n, n, n, n, od(ACC_M, s),
          od(ACC_R, s)}, 2'h0, CC_RES, CC_RES, CC_RES, CC_CLR, 1'b1, 1'b1};
        8'h87, 8'hc7, 8'ha7: info = '{1'b1, 3'h3, {n, n, n, od(ACC_W, s),
          od(ACC_R, s), od(ACC_R, s)}, 2'h0, CC_RES, CC_RES, CC_RES, CC_CLR,
          1'b1, 1'b1};
        8'h7b: info = '{1'b1, 3'h4, {n, n, od(ACC_W, SZ_L), od(ACC_W, SZ_L),
          od(ACC_R, SZ_Q), od(ACC_R, SZ_L)}, 2'h0, CC_RES, CC_RES, CC_RES,
          CC_CLR, 1'b1, 1'b1};
        8'h7a: info = '{1'b1, 3'h4, {n, n, od(ACC_W, SZ_Q), od(ACC_R, SZ_L),
          od(ACC_R, SZ_L), od(ACC_R, SZ_L)}, 2'h0, CC_RES, CC_RES, CC_CLR,
          CC_CLR, 1'b0, 1'b0};
        8'h31: info.disp_len = 2'h2;
        default: begin
          // conditional and unconditional byte branches 11..1f
          if (opcode[7:4] == 4'h1 && opcode[3:0] != 4'h0) info.disp_len = 2'h1;
          else info.known = (opcode[7:0] == 8'h01);
        end
      endcase
    end
  end

endmodule : vld_opc_table
`default_nettype wire

// >>> core/vld_spec_check.sv
// operand specifier split, mode legality check and extension length
`timescale 1ns/10ps
`default_nettype none
module vld_spec_check (
  input wire logic [7:0] spec,
  input wire vld_pkg::vld_opd_s opd,
  input wire logic indexed,
  input wire logic [3:0] idx_reg,
  output logic [3:0] mode,
  output logic [3:0] gen_reg,
  output logic pcrel,
  output logic is_index,
  output logic [3:0] ext_len,
  output logic rsv,
  output logic unpred
);
  import vld_pkg::*;

  logic lit;
  logic auto;

  always_comb begin
    gen_reg = spec[3:0];
    mode = spec[7:4];
    pcrel = (spec[3:0] == REG_PC);
    lit = (spec[7:4] <= MODE_LIT_TOP);
    auto = (mode == MODE_AUTODEC) || (mode == MODE_AUTOINC)
        || (mode == MODE_AUTOINC_DEF);
    is_index = (mode == MODE_INDEX) && !indexed;
    rsv = lit && (opd.acc != ACC_R || indexed);
    if (indexed && (mode == MODE_INDEX || mode == MODE_REG)) rsv = 1'b1;
    if (mode == MODE_REG && opd.acc == ACC_A) rsv = 1'b1;
    unpred = 1'b0;
    if (is_index && pcrel) unpred = 1'b1;
    if (mode == MODE_REG && !pcrel && (opd.sz == SZ_Q || opd.acc == ACC_V))
      unpred = 1'b1;
    if (indexed && auto && !pcrel && gen_reg == idx_reg) unpred = 1'b1;
    if (pcrel && mode == MODE_AUTOINC && (indexed || opd.acc == ACC_M
        || opd.acc == ACC_W || opd.acc == ACC_V)) unpred = 1'b1;
    if (!pcrel && (mode == MODE_REG || mode == MODE_INDEX)) unpred = unpred;
    unique case (mode)
      4'ha, 4'hb: ext_len = 4'h1;
      4'hc, 4'hd: ext_len = 4'h2;
      4'he, 4'hf: ext_len = EXT_LONG;
      MODE_AUTOINC: ext_len = pcrel ? 4'(4'h1 << opd.sz) : 4'h0;
      MODE_AUTOINC_DEF: ext_len = pcrel ? EXT_LONG : 4'h0;
      default: ext_len = 4'h0;
    endcase
  end

endmodule : vld_spec_check
`default_nettype wire

// >>> core/vld_decoder.sv
// variable length instruction decoder with apb control and interrupts
//
// What this block does
// - first opcode byte fd means a second opcode byte follows
// - any other first byte is a complete one-byte opcode
// - zero to six operand specifiers follow, count set by opcode
// - specifier low nibble is register, high nibble is mode; extensions follow
// - register 15 selects pc-relative modes, others general register modes
// - literal modes only for read operands, never as indexed base
// - index mode base must be indexable; index, register, literal fault
// - pc as index register gives unpredictable result
// - register mode on quad or field unpredictable; address access faults
// - auto modes indexed by own base register are unpredictable
// - branch displacement of one or two bytes after specifiers, sign-extended
// - add opcodes update all four flags, may trap integer overflow
// - bit clear/set/test set n and z, clear v, keep c
// - arithmetic shifts set n z v, clear c, may trap overflow
// - narrowing converts set v and trap; widening clear v; all clear c
// - divides set n z v, clear c, trap overflow or divide by zero
// - extended divide: long divisor, quad dividend, traps, clears c
// - extended multiply sets n z, clears v and c
`timescale 1ns/10ps
`default_nettype none
module vld_decoder (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire vld_pkg::vld_qbyte_s qbyte,
  output logic byte_ready,
  output vld_pkg::vld_spec_s spec_out,
  output vld_pkg::vld_insn_s insn_out,
  output vld_pkg::vld_fault_s fault_out,
  output logic irq
);
  import vld_pkg::*;

  typedef struct packed {
    vld_state_e st;
    logic rdy;
    logic [8:0] opc;
    logic [31:0] pc;
    logic [2:0] opn;
    logic indexed;
    logic [3:0] idx_reg;
    logic [3:0] ext_left;
    logic [1:0] ext_pos;
    logic disp_pos;
    logic [15:0] disp;
    logic unp;
    vld_spec_s cur;
    vld_spec_s spec_o;
    vld_insn_s insn_o;
    vld_fault_s fault_o;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic ctrl_en;
    logic [2:0] int_stat;
    logic [2:0] int_en;
    logic [31:0] fault_pc;
    logic [15:0] icount;
    logic irq;
  } vld_regs_s;

  vld_regs_s r;
  vld_regs_s next_r;
  vld_info_s info;
  logic [3:0] c_mode;
  logic [3:0] c_reg;
  logic c_pcrel;
  logic c_index;
  logic [3:0] c_ext;
  logic c_rsv;
  logic c_unp;
  logic take;
  logic apb_done;
  logic [2:0] int_set;

  vld_opc_table u_table (
    .opcode(r.opc),
    .info(info)
  );

  vld_spec_check u_check (
    .spec(qbyte.data),
    .opd(info.opd[r.opn]),
    .indexed(r.indexed),
    .idx_reg(r.idx_reg),
    .mode(c_mode),
    .gen_reg(c_reg),
    .pcrel(c_pcrel),
    .is_index(c_index),
    .ext_len(c_ext),
    .rsv(c_rsv),
    .unpred(c_unp)
  );

  // state to take once `done` operands have been collected
  function automatic vld_state_e after_ops(logic [2:0] done, vld_info_s inf);
    if (done < inf.nops && done < MAX_OPS) after_ops = S_SPEC;
    else if (inf.disp_len != 2'h0) after_ops = S_DISP;
    else after_ops = S_DONE;
  endfunction : after_ops

  function automatic logic reg_known(logic [11:0] a);
    reg_known = (a == OFS_CTRL) || (a == OFS_STATUS) || (a == OFS_FAULT_PC)
      || (a == OFS_INT_STAT) || (a == OFS_INT_CLR) || (a == OFS_INT_EN);
  endfunction : reg_known

  assign take = qbyte.valid && r.rdy;
  assign apb_done = psel && penable && r.pready;

  always_comb begin
    next_r = r;
    int_set = 3'h0;
    next_r.spec_o.valid = 1'b0;
    next_r.insn_o.valid = 1'b0;
    next_r.fault_o.valid = 1'b0;
    unique case (r.st)
      S_OPC1: if (take) begin
        next_r.pc = qbyte.pc;
        next_r.opc = {1'b0, qbyte.data};
        next_r.opn = 3'h0;
        next_r.unp = 1'b0;
        next_r.indexed = 1'b0;
        next_r.disp = 16'h0;
        next_r.disp_pos = 1'b0;
        next_r.st = (qbyte.data == OPC_ESCAPE) ? S_OPC2 : S_LOOK;
      end
      S_OPC2: if (take) begin
        next_r.opc = {1'b1, qbyte.data};
        next_r.st = S_LOOK;
      end
      S_LOOK: next_r.st = after_ops(3'h0, info);
      S_SPEC: if (take) begin
        next_r.cur = '0;
        next_r.cur.num = r.opn;
        next_r.cur.indexed = r.indexed;
        next_r.cur.idx_reg = r.idx_reg;
        next_r.cur.mode = c_mode;
        next_r.cur.gen_reg = c_reg;
        next_r.cur.pcrel = c_pcrel;
        next_r.cur.opd = info.opd[r.opn];
        next_r.cur.unpred = c_unp || (r.indexed && r.cur.unpred);
        next_r.unp = r.unp || c_unp;
        if (c_unp) int_set[INT_UNPRED] = 1'b1;
        if (c_rsv) begin
          // the instruction is dropped, insn_out is not issued for it; specifiers already decoded stay issued
          next_r.fault_o = '{1'b1, r.pc, r.opc};
          next_r.fault_pc = r.pc;
          int_set[INT_FAULT] = 1'b1;
          next_r.st = S_OPC1;
        end else if (c_index) begin
          next_r.indexed = 1'b1;
          next_r.idx_reg = c_reg;
        end else if (c_ext != 4'h0) begin
          next_r.ext_left = c_ext;
          next_r.ext_pos = 2'h0;
          next_r.st = S_EXT;
        end else begin
          next_r.spec_o = next_r.cur;
          next_r.spec_o.valid = 1'b1;
          next_r.indexed = 1'b0;
          next_r.opn = r.opn + 3'h1;
          next_r.st = after_ops(r.opn + 3'h1, info);
        end
      end
      S_EXT: if (take) begin
        // a quad immediate keeps bytes 0..2 in place; bytes 3..7 are all ORed into bits 31:24
        if (r.ext_left > EXT_LONG - 4'h4 && r.ext_pos <= 2'h3 &&
            (r.ext_left + {2'h0, r.ext_pos}) <= EXT_LONG + 4'h4)
          next_r.cur.ext = r.cur.ext | ({24'h0, qbyte.data} << {r.ext_pos, 3'h0});
        if (r.ext_pos != 2'h3) next_r.ext_pos = r.ext_pos + 2'h1;
        next_r.ext_left = r.ext_left - 4'h1;
        if (r.ext_left == 4'h1) begin
          next_r.spec_o = next_r.cur;
          next_r.spec_o.valid = 1'b1;
          next_r.indexed = 1'b0;
          next_r.opn = r.opn + 3'h1;
          next_r.st = after_ops(r.opn + 3'h1, info);
        end
      end
      S_DISP: if (take) begin
        if (!r.disp_pos) next_r.disp[7:0] = qbyte.data;
        else next_r.disp[15:8] = qbyte.data;
        next_r.disp_pos = 1'b1;
        if (r.disp_pos || info.disp_len == 2'h1) next_r.st = S_DONE;
      end
      S_DONE: begin
        next_r.insn_o.valid = 1'b1;
        next_r.insn_o.opcode = r.opc;
        next_r.insn_o.pc = r.pc;
        next_r.insn_o.info = info;
        next_r.insn_o.unpred = r.unp;
        next_r.insn_o.disp = (info.disp_len == 2'h2)
          ? {{16{r.disp[15]}}, r.disp}
          : {{24{r.disp[7]}}, r.disp[7:0]};
        next_r.icount = r.icount + 16'h1;
        int_set[INT_ISSUE] = 1'b1;
        next_r.st = S_OPC1;
      end
    endcase

    // register bus: answer one cycle after the access phase starts
    next_r.pready = psel && penable && !r.pready;
    if (psel && penable && !r.pready) begin
      next_r.pslverr = !reg_known(paddr) || (pwrite && (paddr == OFS_STATUS
        || paddr == OFS_FAULT_PC || paddr == OFS_INT_STAT));
      next_r.prdata = 32'h0;
      if (!pwrite) begin
        unique case (paddr)
          OFS_CTRL: next_r.prdata = {31'h0, r.ctrl_en};
          OFS_STATUS: next_r.prdata = {r.icount, r.opc, r.st};
          OFS_FAULT_PC: next_r.prdata = r.fault_pc;
          OFS_INT_STAT: next_r.prdata = {29'h0, r.int_stat};
          OFS_INT_EN: next_r.prdata = {29'h0, r.int_en};
          default: next_r.prdata = 32'h0;
        endcase
      end
    end else if (!psel) begin
      next_r.pslverr = 1'b0;
    end
    next_r.int_stat = r.int_stat;
    if (apb_done && pwrite) begin
      if (paddr == OFS_CTRL) next_r.ctrl_en = pwdata[0];
      if (paddr == OFS_INT_EN) next_r.int_en = pwdata[2:0];
      if (paddr == OFS_INT_CLR) next_r.int_stat = r.int_stat & ~pwdata[2:0];
    end
    // a new event wins over a clear in the same cycle
    next_r.int_stat = next_r.int_stat | int_set;
    next_r.irq = |(next_r.int_stat & next_r.int_en);
    next_r.rdy = ((next_r.st == S_OPC1) && next_r.ctrl_en)
      || (next_r.st == S_OPC2) || (next_r.st == S_SPEC)
      || (next_r.st == S_EXT) || (next_r.st == S_DISP);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.st <= S_OPC1;
      r.ctrl_en <= RST_CTRL_EN;
      r.int_en <= RST_INT_EN;
    end else begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign byte_ready = r.rdy;
  assign spec_out = r.spec_o;
  assign insn_out = r.insn_o;
  assign fault_out = r.fault_o;
  assign irq = r.irq;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_escape;
    r.st == S_OPC1 && take && qbyte.data == OPC_ESCAPE;
  endsequence
  sequence s_second;
    r.st == S_OPC2 && take;
  endsequence

  property p_escape_two_bytes;
    s_escape |=> r.st == S_OPC2 && r.opc == {1'b0, OPC_ESCAPE};
  endproperty
  a_escape_two_bytes: assert property (p_escape_two_bytes)
    else $error("escape byte did not lead to a two byte opcode");

  property p_second_byte;
    s_second |=> r.st == S_LOOK && r.opc == {1'b1, $past(qbyte.data)};
  endproperty
  a_second_byte: assert property (p_second_byte)
    else $error("second opcode byte not captured");

  property p_single_byte;
    r.st == S_OPC1 && take && qbyte.data != OPC_ESCAPE
      |=> r.st == S_LOOK && r.opc == {1'b0, $past(qbyte.data)};
  endproperty
  a_single_byte: assert property (p_single_byte)
    else $error("single byte opcode not captured");

  property p_op_count;
    insn_out.valid |-> insn_out.info.nops <= MAX_OPS;
  endproperty
  a_op_count: assert property (p_op_count)
    else $error("too many operand specifiers");

  property p_pc_relative;
    spec_out.valid |-> spec_out.pcrel == (spec_out.gen_reg == REG_PC);
  endproperty
  a_pc_relative: assert property (p_pc_relative)
    else $error("pc relative mode set wrongly");

  property p_literal_write_faults;
    r.st == S_SPEC && take && qbyte.data[7:4] <= MODE_LIT_TOP
      && info.opd[r.opn].acc != ACC_R
      |=> fault_out.valid && fault_out.pc == $past(r.pc) ##1 !insn_out.valid;
  endproperty
  a_literal_write_faults: assert property (p_literal_write_faults)
    else $error("literal on non read operand did not fault");

  property p_fault_no_issue;
    fault_out.valid |-> r.st == S_OPC1 && !insn_out.valid
      && r.fault_pc == fault_out.pc;
  endproperty
  a_fault_no_issue: assert property (p_fault_no_issue)
    else $error("faulting instruction was issued");

  property p_disp_sign;
    insn_out.valid && insn_out.info.disp_len == 2'h1
      |-> insn_out.disp[31:8] == {24{insn_out.disp[7]}};
  endproperty
  a_disp_sign: assert property (p_disp_sign)
    else $error("byte displacement not sign extended");

  property p_bit_logic_flags;
    insn_out.valid && insn_out.opcode == 9'h08b
      |-> insn_out.info.cc_v == CC_CLR && insn_out.info.cc_c == CC_KEEP
        && insn_out.info.cc_n == CC_RES;
  endproperty
  a_bit_logic_flags: assert property (p_bit_logic_flags)
    else $error("bit clear flag effects wrong");

  property p_add_flags;
    insn_out.valid && (insn_out.opcode == 9'h080 || insn_out.opcode == 9'h0c0)
      |-> insn_out.info.trap_iov && insn_out.info.cc_c == CC_RES
        && insn_out.info.nops == 3'h2;
  endproperty
  a_add_flags: assert property (p_add_flags)
    else $error("add flag effects wrong");

  property p_irq_level;
    irq == |(r.int_stat & r.int_en);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt level does not follow status and enable");

endmodule : vld_decoder
`default_nettype wire

// >>> dv/vld_queue_model.sv
// prefetch queue model: presents instruction bytes and holds each until taken
`timescale 1ns/10ps
`default_nettype none
module vld_queue_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic byte_ready,
  output vld_pkg::vld_qbyte_s qbyte
);
  import vld_pkg::*;
  logic [7:0] q[$];
  logic [31:0] pcq[$];
  logic [7:0] last;
  task automatic push(input logic [7:0] b, input logic [31:0] a);
    q.push_back(b);
    pcq.push_back(a);
  endtask : push
  // a presented byte stays until taken; idle data shows no stale value
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qbyte <= '0;
      last = 8'h00;
    end else if (!qbyte.valid || byte_ready) begin
      if (qbyte.valid) begin
        last = q.pop_front();
        void'(pcq.pop_front());
      end
      if (q.size() != 0 && !stall) qbyte <= '{1'b1, q[0], pcq[0]};
      else qbyte <= '{1'b0, ~last, 32'h0};
    end
  end
endmodule : vld_queue_model
`default_nettype wire

// >>> dv/tb_vld_decoder.sv
// testbench: apb register access and instruction decoding checks
`timescale 1ns/10ps
`default_nettype none
module tb_vld_decoder;
  import vld_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic byte_ready, irq, stall, slow;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, pc, pcf;
  vld_qbyte_s qbyte;
  vld_spec_s spec_out, sp;
  vld_insn_s insn_out, in;
  vld_fault_s fault_out, ft;
  logic [23:0] tbl[8];
  logic [7:0] b[$];
  int n_errors, total_checks, cyc, n_ev, n_flt;
  vld_decoder vld_decoder_inst (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .qbyte(qbyte), .byte_ready(byte_ready), .spec_out(spec_out),
    .insn_out(insn_out), .fault_out(fault_out), .irq(irq));
  vld_queue_model vld_queue_model_inst (.pclk(pclk), .presetn(presetn),
    .stall(stall), .byte_ready(byte_ready), .qbyte(qbyte));
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    stall <= slow && !stall;
    if (spec_out.valid) sp <= spec_out;
    if (insn_out.valid) begin
      in <= insn_out;
      n_ev++;
    end
    if (fault_out.valid) begin
      ft <= fault_out;
      n_ev++;
      n_flt++;
    end
    if (cyc == 20000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : cmp
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] er,
                     input logic ee);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    cmp(pslverr, ee);
    if (!wr) cmp(prdata, er);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic run();
    int k, n0;
    n0 = n_ev;
    foreach (b[i]) vld_queue_model_inst.push(b[i], pc + 32'(i));
    k = 0;
    while (n_ev == n0 && k < 300) begin
      @(posedge pclk);
      #1;
      k++;
    end
    cmp(k < 300, 1);
    pcf = pc;
    pc = pc + 32'h100;
  endtask : run
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    {psel, penable, pwrite, paddr, pwdata, slow, stall} = '0;
    {n_errors, total_checks, cyc, n_ev, n_flt} = '0;
    pc = 32'h1000;
    presetn = 1'b0;
    // opcode, operand count, n z v c effects, overflow and divide traps
    tbl = '{24'h8b3580, 24'h783562, 24'hf62562, 24'h9825a0,
            24'hc73563, 24'h7b4563, 24'h7a45a0, 24'h813552};
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, OFS_CTRL, 0, 0, 0);
    apb(0, OFS_INT_EN, 0, 0, 0);
    apb(0, OFS_STATUS, 0, 32'h1, 0);
    apb(0, 12'h100, 0, 0, 1);
    apb(1, OFS_STATUS, 1, 0, 1);
    apb(1, OFS_CTRL, 1, 0, 0);
    $display("register test done");
    slow = 1'b1;
    b = '{8'hc0, 8'h50, 8'h51};
    run();
    cmp(in.opcode, 9'h0c0);
    cmp(in.info.nops, 2);
    cmp({sp.num, sp.mode, sp.gen_reg, sp.pcrel}, 12'h2a2);
    slow = 1'b0;
    foreach (tbl[i]) begin
      b = '{tbl[i][23:16]};
      repeat (tbl[i][15:12]) b.push_back(8'h60);
      run();
      cmp(in.info.nops, tbl[i][15:12]);
      cmp({in.info.cc_n, in.info.cc_z, in.info.cc_v, in.info.cc_c},
          tbl[i][11:4]);
      cmp({in.info.trap_iov, in.info.trap_idvz}, tbl[i][1:0]);
    end
    $display("flag table test done");
    b = '{8'hfd, 8'h7d};
    run();
    cmp(in.opcode, 9'h17d);
    b = '{8'h11, 8'hf0};
    run();
    cmp(in.disp, 32'hfffffff0);
    b = '{8'h31, 8'h00, 8'h80};
    run();
    cmp(in.disp, 32'hffff8000);
    b = '{8'hc0, 8'h50, 8'haf, 8'h05};
    run();
    cmp({sp.mode, sp.gen_reg, sp.pcrel}, 9'h15f);
    cmp(sp.ext, 32'h5);
    b = '{8'hc0, 8'h50, 8'h4f, 8'h60};
    run();
    cmp({sp.indexed, sp.unpred, in.unpred}, 3'h7);
    b = '{8'h7a, 8'h60, 8'h60, 8'h60, 8'h50};
    run();
    cmp({sp.num, sp.unpred, in.unpred}, 5'h0f);
    b = '{8'hc0, 8'h60, 8'h42, 8'h82};
    run();
    cmp({sp.indexed, sp.unpred}, 2'h3);
    $display("format test done");
    apb(1, OFS_INT_CLR, 7, 0, 0);
    apb(1, OFS_INT_EN, 1, 0, 0);
    b = '{8'hc0, 8'h00, 8'h00};
    run();
    cmp(ft.pc, pcf);
    cmp({ft.opcode, 23'(n_flt)}, {9'h0c0, 23'h1});
    cmp(in.pc === pcf, 0);
    cmp(irq, 1);
    apb(0, OFS_FAULT_PC, 0, pcf, 0);
    apb(0, OFS_INT_STAT, 0, 1, 0);
    apb(1, OFS_INT_EN, 0, 0, 0);
    @(posedge pclk);
    #1;
    cmp(irq, 0);
    apb(1, OFS_INT_CLR, 1, 0, 0);
    apb(0, OFS_INT_STAT, 0, 0, 0);
    b = '{8'hc0, 8'h41, 8'h00};
    run();
    cmp(n_flt, 2);
    b = '{8'hc0, 8'h60, 8'h41, 8'h51};
    run();
    cmp(n_flt, 3);
    $display("fault test done");
    print_verdict();
  end
endmodule : tb_vld_decoder
`default_nettype wire
